// ==== pkg/spdb_defines.vh ====
// Purpose: Constants for the synthesizer post-divider bank
// Assumes: Byte-wide register access, three bytes per divider
// Notes: Lowest address of a register holds its most significant byte
`ifndef SPDB_DEFINES_VH
`define SPDB_DEFINES_VH

`define SPDB_DIV_A_OFS 8'h98
`define SPDB_DIV_B_OFS 8'h9B
`define SPDB_DIV_C_OFS 8'h9E
`define SPDB_DIV_D_OFS 8'hA1
`define SPDB_BYTES_PER_REG 2'h3
`define SPDB_LAST_BYTE 2'h2
`define SPDB_CFG_RESET 24'h000000
`define SPDB_UNMAPPED_DATA 8'h00

`define SPDB_RATE_MSB 15
`define SPDB_RATE_LSB 0
`define SPDB_SRC_MSB 17
`define SPDB_SRC_LSB 16
`define SPDB_POL_BIT 18
`define SPDB_FMT_BIT 19
`define SPDB_MODE_MSB 23
`define SPDB_MODE_LSB 20
`define SPDB_MODE_SPECIAL 4'hF

`define SPDB_KIND_DIV 2'h0
`define SPDB_KIND_LF 2'h1
`define SPDB_KIND_FRAME 2'h2

`endif

// ==== design/spdb_post_divider_bank.v ====
// Purpose: Four post-dividers producing divided clocks, low-frequency clocks or frame pulses
// Assumes: clk is the synthesizer output clock; base_tick pulses once per base-clock period
// Notes: Divided outputs are registered and follow clk edges; odd ratios are high one extra cycle
`timescale 1ns/1ps
`include "spdb_defines.vh"

// Function
// - Normal mode divides output clock by 24-bit ratio
// - Own source code gives base-clock low-frequency clock
// - Other source gives frame pulse, one period wide
// - Pulse spacing is low 16 bits periods
// - Polarity bit zero high pulse, one low
// - Format bit picks centred or leading-edge boundary
// - Outside special mode control bits are ratio
// - Mode field F picks frame or low-frequency, other values regular clock
// - Source field selects a sibling divider clock
// - Divider B source decode A, LF, C, D
// - Divider C source decode A, B, LF, D
// - Divider D source decode A, B, C, LF
// - Config registers read/write, reset to zero
// - Divider A source decode LF, B, C, D
module spdb_post_divider_bank (
  input wire clk,
  input wire nrst,
  input wire base_tick,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output wire [3:0] div_out
);

  // Returns {hit, divider index, byte index}
  function [4:0] spdb_decode;
    input [7:0] addr;
    reg [7:0] base;
    reg [7:0] off;
    integer k;
    begin
      spdb_decode = 5'h00;
      off = 8'h00;
      for (k = 0; k < 4; k = k + 1) begin
        base = `SPDB_DIV_A_OFS + k[7:0] * {6'h00, `SPDB_BYTES_PER_REG};
        if (addr >= base && addr < base + {6'h00, `SPDB_BYTES_PER_REG}) begin
          // Byte index within the register is the low two bits of the offset
          off = addr - base;
          spdb_decode = {1'b1, k[1:0], off[1:0]};
        end
      end
    end
  endfunction

  // Classifies a configuration word for divider index idx
  function [1:0] spdb_kind;
    input [23:0] cfg;
    input [1:0] idx;
    begin
      if (cfg[`SPDB_MODE_MSB:`SPDB_MODE_LSB] != `SPDB_MODE_SPECIAL) begin
        spdb_kind = `SPDB_KIND_DIV;
      end else if (cfg[`SPDB_SRC_MSB:`SPDB_SRC_LSB] == idx) begin
        spdb_kind = `SPDB_KIND_LF;
      end else begin
        spdb_kind = `SPDB_KIND_FRAME;
      end
    end
  endfunction

  wire [4:0] wdec;
  wire [4:0] rdec;
  wire [3:0] clk_vec;
  wire [95:0] sh_vec;

  assign wdec = spdb_decode(reg_addr);
  assign rdec = spdb_decode(reg_addr);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `SPDB_UNMAPPED_DATA;
    end else if (reg_rd) begin
      if (!rdec[4]) begin
        reg_rdata <= `SPDB_UNMAPPED_DATA;
      end else begin
        case (rdec[1:0])
          2'h0: reg_rdata <= sh_vec[rdec[3:2] * 24 + 16 +: 8];
          2'h1: reg_rdata <= sh_vec[rdec[3:2] * 24 + 8 +: 8];
          default: reg_rdata <= sh_vec[rdec[3:2] * 24 +: 8];
        endcase
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_div
      localparam [1:0] IDX = gi;
      reg [23:0] sh_q;
      reg [23:0] act_q;
      reg [23:0] cnt_q;
      reg [23:0] cnt_d;
      reg [23:0] ratio;
      reg [23:0] half;
      reg clk_q;
      reg src_d1_q;
      reg [15:0] fcnt_q;
      reg fp_q;
      reg out_q;
      wire [1:0] kind;
      wire [1:0] src;
      wire sel_clk;
      wire rise;
      wire fall;
      wire [15:0] rate;
      wire [15:0] last;
      wire wr_me;

      assign wr_me = reg_wr && wdec[4] && (wdec[3:2] == IDX);
      assign kind = spdb_kind(act_q, IDX);
      assign src = act_q[`SPDB_SRC_MSB:`SPDB_SRC_LSB];
      assign sel_clk = clk_vec[src];
      assign rise = sel_clk && !src_d1_q;
      assign fall = !sel_clk && src_d1_q;
      assign rate = act_q[`SPDB_RATE_MSB:`SPDB_RATE_LSB];
      assign last = (rate <= 16'h0001) ? 16'h0000 : rate - 16'h0001;
      assign sh_vec[gi * 24 +: 24] = sh_q;
      assign clk_vec[gi] = clk_q;
      assign div_out[gi] = out_q;

      // stage bytes, commit on last byte
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          sh_q <= `SPDB_CFG_RESET;
          act_q <= `SPDB_CFG_RESET;
        end else if (wr_me) begin
          case (wdec[1:0])
            2'h0: sh_q[23:16] <= reg_wdata;
            2'h1: sh_q[15:8] <= reg_wdata;
            default: begin
              sh_q[7:0] <= reg_wdata;
              act_q <= {sh_q[23:8], reg_wdata};
            end
          endcase
        end
      end

      // whole word is ratio in normal mode
      always @* begin
        ratio = (kind == `SPDB_KIND_DIV) ? act_q : {8'h00, rate};
        half = (ratio >> 1) + {23'h000000, ratio[0]};
        cnt_d = (cnt_q >= ratio - 24'h000001) ? 24'h000000 : cnt_q + 24'h000001;
      end

      // clk division by whole ratio in normal mode, base-tick division by low 16 bits in low-frequency mode
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          cnt_q <= 24'h000000;
          clk_q <= 1'b0;
        end else if (kind == `SPDB_KIND_FRAME || ratio < 24'h000002) begin
          cnt_q <= 24'h000000;
          clk_q <= 1'b0;
        end else if (kind == `SPDB_KIND_DIV || base_tick) begin
          cnt_q <= cnt_d;
          clk_q <= (cnt_d < half);
        end
      end

      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          src_d1_q <= 1'b0;
          fcnt_q <= 16'h0000;
          fp_q <= 1'b0;
        end else begin
          src_d1_q <= sel_clk;
          if (kind != `SPDB_KIND_FRAME) begin
            fcnt_q <= 16'h0000;
            fp_q <= 1'b0;
          end else begin
            if (rise) begin
              fcnt_q <= (fcnt_q >= last) ? 16'h0000 : fcnt_q + 16'h0001;
            end
            if (act_q[`SPDB_FMT_BIT] && rise) begin
              fp_q <= (fcnt_q >= last);
            end else if (!act_q[`SPDB_FMT_BIT] && fall) begin
              fp_q <= (fcnt_q == last);
            end
          end
        end
      end

      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          out_q <= 1'b0;
        end else if (kind == `SPDB_KIND_FRAME) begin
          out_q <= fp_q ^ act_q[`SPDB_POL_BIT];
        end else begin
          out_q <= clk_q;
        end
      end
    end
  endgenerate

endmodule // spdb_post_divider_bank

// ==== testbench/spdb_bank_sva.sv ====
// Purpose: Port checks for the post-divider bank
// Assumes: Byte bus with registered read data
// Notes: Bound to the design top
`timescale 1ns/1ps
module spdb_bank_chk (
  input wire clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [3:0] div_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  reg arm_q, seen_q;
  wire m = reg_addr >= 8'h98 && reg_addr <= 8'hA3;
  wire l = reg_addr inside {8'h9A, 8'h9D, 8'hA0, 8'hA3};
  // Outputs may only move once the last byte of some register has been written
  always @(posedge clk or negedge nrst)
    if (!nrst) {arm_q, seen_q} <= 2'b00;
    else {arm_q, seen_q} <= {arm_q | reg_wr & l, seen_q | reg_wr};
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_wr_no_answer: assert property (reg_wr && !reg_rd |=> $stable(reg_rdata))
    else $error("write disturbed read data");
  a_unmapped_zero: assert property (reg_rd && !m |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_value: assert property (reg_rd && !seen_q |=> reg_rdata == 8'h00)
    else $error("register not zero after reset");
  a_write_back: assert property (reg_wr && !reg_rd && m ##1 reg_rd && !reg_wr
    && reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("written byte not read back");
  a_read_repeat: assert property (reg_rd && !reg_wr ##1 reg_rd && !reg_wr
    && $stable(reg_addr) |=> $stable(reg_rdata))
    else $error("repeated read differs");
  a_idle_low: assert property (!arm_q |-> div_out == 4'h0)
    else $error("output moved before a full write");
  a_reset_low: assert property (@(posedge clk) disable iff (1'b0)
    !nrst |-> div_out == 4'h0 && reg_rdata == 8'h00)
    else $error("outputs not cleared in reset");
endmodule // spdb_bank_chk
bind spdb_post_divider_bank spdb_bank_chk u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .div_out(div_out));

// ==== testbench/spdb_clock_sink.sv ====
// Purpose: Downstream sink timing each output
// Assumes: Outputs settle on clk
// Notes: per is rise to rise, hi is rise to fall, in clk cycles
`timescale 1ns/1ps
module spdb_clock_sink (
  input wire clk,
  input wire [3:0] div_out,
  output int per [4],
  output int hi [4]
);
  int t [4];
  reg [3:0] old_q;
  always @(posedge clk) begin
    old_q <= div_out;
    for (int i = 0; i < 4; i++) begin
      t[i] = t[i] + 1;
      if (div_out[i] && !old_q[i]) begin
        per[i] = t[i];
        t[i] = 0;
      end
      if (!div_out[i] && old_q[i]) hi[i] = t[i];
    end
  end
endmodule // spdb_clock_sink

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the post-divider bank
// Assumes: base_tick every third clk
// Notes: Expected timing comes from the bench model
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0, nrst = 1'b0, base_tick = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
  wire [7:0] reg_rdata;
  wire [3:0] div_out;
  int per [4], hi [4], ep [4], eh [4], errors = 0, check_count = 0, cyc = 0, na;
  reg [31:0] seed = 32'h2dc54590;
  reg [23:0] cfg [$];
  always #2.5 clk = ~clk;
  spdb_post_divider_bank DUT (.clk(clk), .nrst(nrst), .base_tick(base_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .div_out(div_out));
  spdb_clock_sink sink (.clk(clk), .div_out(div_out), .per(per), .hi(hi));
  task end_sim;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    base_tick <= (cyc % 3) == 0;
    if (cyc > 5000) begin
      errors++;
      end_sim();
    end
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string n, input logic [23:0] e, input logic [23:0] s);
    check_count++;
    if (e !== s) begin
      errors++;
      $display("CHECK FAILED %s exp %0d got %0d", n, e, s);
    end
  endtask
  // Read stays asserted until the next access so reads run back to back
  task rd(input [7:0] a);
    @(posedge clk);
    {reg_wr, reg_rd, reg_addr} <= {2'b01, a};
    @(posedge clk);
    @(negedge clk);
    d = reg_rdata;
  endtask
  task wcfg(input int k, input [23:0] v);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {reg_wr, reg_rd, reg_addr} <= {2'b10, 8'(8'h98 + 3 * k + i)};
      reg_wdata <= v[23 - 8 * i -: 8];
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      rd(8'(8'h97 + i));
      chk("reset_byte", 0, d);
    end
    seed = lfsr(seed);
    na = 2 * (seed % 5) + 4;
    cfg = '{24'(na), 24'hF10004, 24'hF80003, 24'hF50003, 24'h123456};
    for (int k = 0; k < 5; k++) begin
      wcfg(k, cfg[k]);
      rd(8'(8'h9A + 3 * k));
      chk("last_byte", k < 4 ? cfg[k][7:0] : 8'h00, d);
    end
    ep = '{na, 12, 3 * na, 36};
    eh = '{na / 2, 6, na, 24};
    repeat (300) @(posedge clk);
    @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      chk("period", ep[k], per[k]);
      chk("high", eh[k], hi[k]);
    end
    for (int i = 0; i < 12; i++) begin
      rd(8'(8'h98 + i));
      chk("readback", cfg[i / 3][23 - 8 * (i % 3) -: 8], d);
    end
    end_sim();
  end
endmodule // testbench
